// ---- logic/mpt_chain.v ----
// prescaler and 15-stage counter chain with overflow and periodic taps
`timescale 1ns/1ps
`include "mpt_defines.vh"

module mpt_chain (
    input wire clk_i,           // system clock
    input wire nrst_i,          // async reset, active low
    input wire clear_i,         // synchronous clear of prescaler and stages
    output reg [14:0] count_o,  // counter stages
    output reg ovf_o,           // pulse: low eight stages wrapped
    output reg [3:0] tap_o      // pulses: carry out of stages 11..14
);

    reg [1:0] pre_reg;
    wire adv;
    wire [3:0] tap_next;

    // the counter only moves on the prescaler wrap, i.e. every fourth clock
    assign adv = (pre_reg == `MPT_PRE_LAST);

    // one carry tap per periodic rate, each one stage longer than the last
    genvar g;
    generate
        for (g = 0; g < `MPT_NUM_TAPS; g = g + 1) begin : g_tap
            assign tap_next[g] = adv & (&count_o[`MPT_TAP_BASE + g:0]);
        end
    endgenerate

    always @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            pre_reg <= `MPT_PRE_RST;
            count_o <= `MPT_CNT_RST;
            ovf_o <= 1'b0;
            tap_o <= 4'h0;
        end else if (clear_i) begin
            pre_reg <= `MPT_PRE_RST;
            count_o <= `MPT_CNT_RST;
            ovf_o <= 1'b0;
            tap_o <= 4'h0;
        end else begin
            pre_reg <= pre_reg + 2'h1;
            if (adv) begin
                count_o <= count_o + 15'h0001;
            end
            ovf_o <= adv & (count_o[7:0] == `MPT_LOW_LAST);
            tap_o <= tap_next;
        end
    end

endmodule // mpt_chain

// ---- logic/mpt_defines.vh ----
// constants for the multifunction periodic timer
`ifndef MPT_DEFINES_VH
`define MPT_DEFINES_VH

// register indices; the bus byte address is four times the index
`define MPT_IDX_CTRL 6'h08
`define MPT_IDX_COUNT 6'h09
`define MPT_IDX_ISTAT 6'h0a
`define MPT_IDX_IMASK 6'h0b

// timer_ctrl_status bit positions
`define MPT_B_OVF_FLAG 7
`define MPT_B_PER_FLAG 6
`define MPT_B_OVF_IE 5
`define MPT_B_PER_IE 4
`define MPT_B_OVF_CLR 3
`define MPT_B_PER_CLR 2
`define MPT_B_RATE_HI 1
`define MPT_B_RATE_LO 0

// interrupt status and mask bit positions
`define MPT_I_OVF 0
`define MPT_I_PER 1

// reset values
`define MPT_RATE_RST 2'h3
`define MPT_MASK_RST 2'h0
`define MPT_CNT_RST 15'h0000
`define MPT_PRE_RST 2'h0
`define MPT_WDOG_RST 3'h0

// chain geometry: prescaler of four, 15 stages, 8 readable, taps from stage 11
`define MPT_PRE_LAST 2'h3
`define MPT_LOW_LAST 8'hff
`define MPT_TAP_BASE 11
`define MPT_NUM_TAPS 4

// the watchdog times out on the eighth periodic tap
`define MPT_WDOG_LAST 3'h7

`endif

// ---- logic/mpt_timer.v ----
// multifunction periodic timer: avalon slave, flags, interrupts, watchdog feed
//
// How it works
// - prescale by four, then 15-stage counter
// - low eight stages readable as count register
// - overflow flag on low byte wrap
// - rate select picks one of four taps
// - periodic flag on tap, request if enabled
// - overflow request only when enable set
// - write one clears overflow flag, reads zero
// - write one clears periodic flag, reads zero
// - flags ignore direct writes
// - reset clears flags, enables; rate slowest
// - selected tap clocks watchdog chain
// - stop clears counter, flags and enables
// - wait keeps counting; enabled requests wake
//
// The Avalon-MM register port was chosen for this implementation.
`timescale 1ns/1ps
`include "mpt_defines.vh"

module mpt_timer (
    input wire clk_i,                   // system clock, 100 MHz
    input wire nrst_i,                  // async reset, active low
    input wire [7:0] avs_address_i,     // avalon byte address
    input wire avs_read_i,              // avalon read
    input wire avs_write_i,             // avalon write
    input wire [31:0] avs_writedata_i,  // avalon write data
    input wire [3:0] avs_byteenable_i,  // avalon byte enables
    output reg [31:0] avs_readdata_o,   // avalon read data
    output reg avs_waitrequest_o,       // avalon waitrequest
    input wire stop_i,                  // stop mode level from the core
    input wire wait_i,                  // wait mode level from the core
    input wire wdog_service_i,          // pulse: watchdog serviced
    output reg irq_o,                   // level: unmasked status bit set
    output reg overflow_req_o,          // level: overflow request
    output reg periodic_req_o,          // level: periodic request
    output reg wake_o,                  // level: enabled request during wait
    output reg periodic_tick_o,         // pulse: selected tap fired
    output reg wdog_timeout_o           // pulse: watchdog chain expired
);

    // bus handshake states, one-hot
    localparam ST_IDLE = 2'b01;
    localparam ST_ACK = 2'b10;

    // register byte addresses
    localparam [7:0] A_CTRL = {`MPT_IDX_CTRL, 2'b00};
    localparam [7:0] A_COUNT = {`MPT_IDX_COUNT, 2'b00};
    localparam [7:0] A_ISTAT = {`MPT_IDX_ISTAT, 2'b00};
    localparam [7:0] A_IMASK = {`MPT_IDX_IMASK, 2'b00};

    reg [1:0] state_reg;
    reg [1:0] state_next;
    reg overflow_flag_reg;
    reg periodic_flag_reg;
    reg overflow_irq_enable_reg;
    reg periodic_irq_enable_reg;
    reg [1:0] rate_sel_reg;
    reg [1:0] istat_reg;
    reg [1:0] imask_reg;
    reg [1:0] istat_cap_reg;
    reg istat_rd_reg;
    reg [2:0] wdog_cnt_reg;

    reg overflow_flag_next;
    reg periodic_flag_next;
    reg [1:0] istat_next;
    reg [2:0] wdog_cnt_next;
    reg [7:0] rd_mux;

    wire [14:0] count;
    wire ovf_ev;
    wire [3:0] taps;
    wire per_ev;
    wire req;
    wire take;
    wire wr_ctrl;
    wire wr_imask;
    wire [7:0] ctrl_view;

    mpt_chain u_chain (
        .clk_i(clk_i),
        .nrst_i(nrst_i),
        .clear_i(stop_i),
        .count_o(count),
        .ovf_o(ovf_ev),
        .tap_o(taps)
    );

    assign per_ev = taps[rate_sel_reg];

    // a request is taken at the edge that ends the one low-waitrequest cycle
    assign req = avs_read_i | avs_write_i;
    assign take = req & (state_reg == ST_ACK);
    assign wr_ctrl = take & avs_write_i & avs_byteenable_i[0] & (avs_address_i == A_CTRL);
    assign wr_imask = take & avs_write_i & avs_byteenable_i[0] & (avs_address_i == A_IMASK);

    assign ctrl_view = {overflow_flag_reg, periodic_flag_reg,
                        overflow_irq_enable_reg, periodic_irq_enable_reg,
                        1'b0, 1'b0, rate_sel_reg};

    // handshake: one wait cycle, then one answer cycle
    always @* begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE: begin
                if (req) begin
                    state_next = ST_ACK;
                end
            end
            ST_ACK: begin
                state_next = ST_IDLE;
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
    end

    // read mux; unmapped addresses read zero
    always @* begin
        rd_mux = 8'h00;
        if (avs_address_i == A_CTRL) begin
            rd_mux = ctrl_view;
        end else if (avs_address_i == A_COUNT) begin
            rd_mux = count[7:0];
        end else if (avs_address_i == A_ISTAT) begin
            rd_mux = {6'h00, istat_reg};
        end else if (avs_address_i == A_IMASK) begin
            rd_mux = {6'h00, imask_reg};
        end
    end

    // flag next values: a hardware set in the same cycle beats a clear
    always @* begin
        overflow_flag_next = overflow_flag_reg;
        periodic_flag_next = periodic_flag_reg;
        if (wr_ctrl && avs_writedata_i[`MPT_B_OVF_CLR]) begin
            overflow_flag_next = 1'b0;
        end
        if (wr_ctrl && avs_writedata_i[`MPT_B_PER_CLR]) begin
            periodic_flag_next = 1'b0;
        end
        if (ovf_ev) begin
            overflow_flag_next = 1'b1;
        end
        if (per_ev) begin
            periodic_flag_next = 1'b1;
        end
        if (stop_i) begin
            overflow_flag_next = 1'b0;
            periodic_flag_next = 1'b0;
        end
    end

    // sticky status: a read clears only the bits it returned
    always @* begin
        istat_next = istat_reg;
        if (istat_rd_reg) begin
            istat_next = istat_reg & ~istat_cap_reg;
        end
        istat_next[`MPT_I_OVF] = istat_next[`MPT_I_OVF] | ovf_ev;
        istat_next[`MPT_I_PER] = istat_next[`MPT_I_PER] | per_ev;
        if (stop_i) begin
            istat_next = 2'h0;
        end
    end

    // watchdog chain counts selected taps; service or stop restarts it
    always @* begin
        wdog_cnt_next = wdog_cnt_reg;
        if (stop_i || wdog_service_i) begin
            wdog_cnt_next = `MPT_WDOG_RST;
        end else if (per_ev) begin
            wdog_cnt_next = wdog_cnt_reg + 3'h1;
        end
    end

    // bus slave registers
    always @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            state_reg <= ST_IDLE;
            avs_waitrequest_o <= 1'b1;
            avs_readdata_o <= 32'h00000000;
            istat_cap_reg <= 2'h0;
            istat_rd_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            // waitrequest falls only for the answer cycle
            avs_waitrequest_o <= (state_next != ST_ACK);
            istat_rd_reg <= 1'b0;
            if (state_reg == ST_IDLE && req) begin
                avs_readdata_o <= {24'h000000, rd_mux};
                // remember what the read returns so later events survive the clear
                istat_cap_reg <= istat_reg;
            end
            if (take && avs_read_i && avs_address_i == A_ISTAT) begin
                istat_rd_reg <= 1'b1;
            end
        end
    end

    // control state
    always @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            overflow_flag_reg <= 1'b0;
            periodic_flag_reg <= 1'b0;
            overflow_irq_enable_reg <= 1'b0;
            periodic_irq_enable_reg <= 1'b0;
            rate_sel_reg <= `MPT_RATE_RST;
            istat_reg <= 2'h0;
            imask_reg <= `MPT_MASK_RST;
            wdog_cnt_reg <= `MPT_WDOG_RST;
        end else begin
            overflow_flag_reg <= overflow_flag_next;
            periodic_flag_reg <= periodic_flag_next;
            istat_reg <= istat_next;
            wdog_cnt_reg <= wdog_cnt_next;
            if (stop_i) begin
                overflow_irq_enable_reg <= 1'b0;
                periodic_irq_enable_reg <= 1'b0;
            end else if (wr_ctrl) begin
                overflow_irq_enable_reg <= avs_writedata_i[`MPT_B_OVF_IE];
                periodic_irq_enable_reg <= avs_writedata_i[`MPT_B_PER_IE];
            end
            if (wr_ctrl) begin
                rate_sel_reg <= {avs_writedata_i[`MPT_B_RATE_HI],
                                 avs_writedata_i[`MPT_B_RATE_LO]};
            end
            if (wr_imask) begin
                imask_reg <= {avs_writedata_i[`MPT_I_PER], avs_writedata_i[`MPT_I_OVF]};
            end
        end
    end

    // registered outputs; each lags its cause by one clock
    always @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            irq_o <= 1'b0;
            overflow_req_o <= 1'b0;
            periodic_req_o <= 1'b0;
            wake_o <= 1'b0;
            periodic_tick_o <= 1'b0;
            wdog_timeout_o <= 1'b0;
        end else begin
            irq_o <= |(istat_reg & imask_reg);
            overflow_req_o <= overflow_flag_reg & overflow_irq_enable_reg;
            periodic_req_o <= periodic_flag_reg & periodic_irq_enable_reg;
            wake_o <= wait_i & ((overflow_flag_reg & overflow_irq_enable_reg) |
                                (periodic_flag_reg & periodic_irq_enable_reg));
            periodic_tick_o <= per_ev;
            // eighth tap expires; a rate change shifts the timeout
            wdog_timeout_o <= per_ev & ~stop_i & ~wdog_service_i &
                              (wdog_cnt_reg == `MPT_WDOG_LAST);
        end
    end

endmodule // mpt_timer

// ---- test/mpt_timer_props.sv ----
// port checker for the multifunction periodic timer
`timescale 1ns/1ps
module mpt_timer_props (
    input wire clk_i, // clock
    input wire nrst_i, // reset, low
    input wire [7:0] avs_address_i, // address
    input wire avs_read_i, // read
    input wire avs_write_i, // write
    input wire [31:0] avs_readdata_o, // read data
    input wire avs_waitrequest_o, // wait
    input wire stop_i, // stop mode
    input wire wait_i, // wait mode
    input wire overflow_req_o, // overflow req
    input wire periodic_req_o, // periodic req
    input wire wake_o, // wake
    input wire periodic_tick_o // tick
);
    int since_tick;
    // cycles since last tick; stop restarts the chain, so the count restarts too
    always @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            since_tick <= 0;
        end else if (periodic_tick_o || stop_i) begin
            since_tick <= 0;
        end else if (since_tick < 99999) begin
            since_tick <= since_tick + 1;
        end
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!nrst_i);
    a_wait_one_cycle: assert property ($fell(avs_waitrequest_o) |=> avs_waitrequest_o)
        else $error("waitrequest low too long");
    a_req_answered: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o
        |-> ##[1:2] !avs_waitrequest_o) else $error("request not answered");
    a_hi_bits_zero: assert property (!avs_waitrequest_o |-> avs_readdata_o[31:8] == 24'h0)
        else $error("read data upper bits set");
    a_clr_reads_zero: assert property (!avs_waitrequest_o && avs_read_i &&
        avs_address_i == 8'h20 |-> avs_readdata_o[3:2] == 2'b00) else $error("clear bits read 1");
    a_tick_one_cycle: assert property (periodic_tick_o |=> !periodic_tick_o)
        else $error("tick longer than one cycle");
    a_tick_spacing: assert property (periodic_tick_o |-> since_tick >= 16383)
        else $error("ticks too close");
    a_stop_clears: assert property (stop_i [*3] |-> !overflow_req_o && !periodic_req_o)
        else $error("request during stop");
    a_wake_needs_wait: assert property (wake_o |-> $past(wait_i))
        else $error("wake without wait mode");
    c_ovf: cover property ($rose(overflow_req_o));
    c_tick: cover property (periodic_tick_o);
    c_wake: cover property (wake_o);
endmodule // mpt_timer_props

bind mpt_timer mpt_timer_props u_props (.clk_i, .nrst_i, .avs_address_i, .avs_read_i,
    .avs_write_i, .avs_readdata_o, .avs_waitrequest_o, .stop_i, .wait_i, .overflow_req_o,
    .periodic_req_o, .wake_o, .periodic_tick_o);

// ---- test/tb_top.sv ----
// self-checking bench for the multifunction periodic timer
`timescale 1ns/1ps
module tb_top;
    logic clk_i = 1'b0, nrst_i = 1'b0, avs_read_i = 1'b0, avs_write_i = 1'b0;
    logic stop_i = 1'b0, wait_i = 1'b0, wdog_service_i = 1'b0;
    logic [7:0] avs_address_i = 8'h00;
    logic [31:0] avs_writedata_i = 32'h0, avs_readdata_o, rd, c1;
    logic [3:0] avs_byteenable_i = 4'hf;
    logic avs_waitrequest_o, irq_o, overflow_req_o, periodic_req_o, wake_o;
    logic periodic_tick_o, wdog_timeout_o;
    logic [7:0] ra [4] = '{8'h20, 8'h2c, 8'h28, 8'h30};
    logic [31:0] rv [4] = '{32'h3, 32'h0, 32'h0, 32'h0};
    int num_errors = 0, checks = 0, cyc = 0, t1 = 0, t_rd = 0;
    mpt_timer u_dut (.clk_i, .nrst_i, .avs_address_i, .avs_read_i, .avs_write_i,
        .avs_writedata_i, .avs_byteenable_i, .avs_readdata_o, .avs_waitrequest_o, .stop_i,
        .wait_i, .wdog_service_i, .irq_o, .overflow_req_o, .periodic_req_o, .wake_o,
        .periodic_tick_o, .wdog_timeout_o);
    initial forever #5 clk_i = ~clk_i;
    always @(posedge clk_i) cyc <= cyc + 1;
    // the bench never lets eight periodic taps pass unserviced, so no timeout may show
    always @(posedge clk_i) if (nrst_i && wdog_timeout_o !== 1'b0) check(wdog_timeout_o, 0);
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    // one avalon access; an extra edge after release keeps strobes from double assignment
    task automatic bus(input bit wr, input logic [7:0] a, input logic [31:0] d,
        input logic [3:0] be);
        int n;
        n = 0;
        avs_address_i <= a;
        avs_writedata_i <= d;
        avs_byteenable_i <= be;
        avs_read_i <= !wr;
        avs_write_i <= wr;
        do begin
            @(posedge clk_i);
            n++;
        end while (avs_waitrequest_o !== 1'b0 && n < 20);
        rd = avs_readdata_o;
        t_rd = cyc;
        avs_read_i <= 1'b0;
        avs_write_i <= 1'b0;
        @(posedge clk_i);
        check(32'(n < 20), 32'h1);
    endtask
    // waits for the tick or the overflow request, bounded
    task automatic wait_hi(input bit per, input int lim);
        int n;
        n = 0;
        while ((per ? periodic_tick_o : overflow_req_o) !== 1'b1 && n < lim) begin
            @(posedge clk_i);
            n++;
        end
        check(32'(n < lim), 32'h1);
    endtask
    task automatic close_out();
        $display("checks %0d num_errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    // hang guard, about two and a half times the expected run
    initial begin
        repeat (80000) @(posedge clk_i);
        num_errors++;
        close_out();
    end
    initial begin
        void'($urandom(54));
        repeat (6) @(posedge clk_i);
        nrst_i <= 1'b1;
        @(posedge clk_i);
        // narrow write is ignored, then reset values and an unmapped read
        bus(1, 8'h20, 32'hff, 4'he);
        foreach (ra[i]) begin
            bus(0, ra[i], 32'h0, 4'hf);
            check(rd, rv[i]);
        end
        // count advances once per four clocks and ignores writes
        bus(0, 8'h24, 32'h0, 4'hf);
        c1 = rd;
        t1 = t_rd;
        bus(1, 8'h24, $urandom, 4'hf);
        repeat (250) @(posedge clk_i);
        bus(0, 8'h24, 32'h0, 4'hf);
        check(rd, (c1 + (t_rd - t1) / 4) & 32'hff);
        // random writes to flag positions, overflow enable and mask on
        bus(1, 8'h2c, 32'h1, 4'hf);
        bus(1, 8'h20, 32'h20 | ($urandom & 32'hc0), 4'hf);
        bus(0, 8'h20, 32'h0, 4'hf);
        check(rd, 32'h20);
        wait_hi(0, 1100);
        t1 = cyc;
        repeat (2) @(posedge clk_i);
        check(irq_o, 1);
        bus(0, 8'h28, 32'h0, 4'hf);
        check(rd, 32'h1);
        bus(1, 8'h20, 32'h28, 4'hf);
        bus(0, 8'h20, 32'h0, 4'hf);
        check(rd, 32'h20);
        check({overflow_req_o, irq_o}, 0);
        // masked event keeps the interrupt low
        bus(1, 8'h2c, 32'h0, 4'hf);
        wait_hi(0, 1100);
        check(32'(cyc - t1), 32'd1024);
        check(irq_o, 0);
        // fastest rate with periodic enable
        bus(1, 8'h20, 32'h18, 4'hf);
        wait_hi(1, 17000);
        t1 = cyc;
        @(posedge clk_i);
        wait_hi(1, 17000);
        check(32'(cyc - t1), 32'd16384);
        repeat (2) @(posedge clk_i);
        check(periodic_req_o, 1);
        wait_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        check(wake_o, 1);
        wait_i <= 1'b0;
        bus(1, 8'h20, 32'h14, 4'hf);
        bus(0, 8'h20, 32'h0, 4'hf);
        check(rd & 32'h7f, 32'h10);
        // stop clears enables and flags but keeps the rate
        // service the watchdog before the rate changes
        wdog_service_i <= 1'b1;
        @(posedge clk_i);
        wdog_service_i <= 1'b0;
        check(wdog_timeout_o, 0);
        bus(1, 8'h20, 32'h31, 4'hf);
        stop_i <= 1'b1;
        wdog_service_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        stop_i <= 1'b0;
        wdog_service_i <= 1'b0;
        bus(0, 8'h20, 32'h0, 4'hf);
        check(rd, 32'h1);
        bus(0, 8'h24, 32'h0, 4'hf);
        check(32'(rd < 8), 32'h1);
        close_out();
    end
endmodule // tb_top
